// [pcr_defs.vh]
`ifndef PCR_DEFS_VH
`define PCR_DEFS_VH

// ====================
// register indices (byte address is four times the index)
`define PCR_IDX_W          7
`define PCR_IDX_LCD_ADDR   7'h0A
`define PCR_IDX_LCD_BUF    7'h0B
`define PCR_IDX_CNT_RUN    7'h0C
`define PCR_IDX_SYS_CTL    7'h0D
`define PCR_IDX_IR_CTL     7'h0E
`define PCR_IDX_IRQ_FLAG   7'h0F
`define PCR_IDX_GPR_LO     7'h10
`define PCR_IDX_GPR_BANKED 7'h20
`define PCR_IDX_GPR_HI     7'h3F
`define PCR_IDX_BANK_SEL   7'h40
`define PCR_IDX_LCD_COM    7'h41
`define PCR_IDX_P5_DIR     7'h42
`define PCR_IDX_P5_DATA    7'h43

// ====================
// field positions
`define PCR_SYS_PLL_HI     6
`define PCR_SYS_PLL_LO     4
`define PCR_SYS_IDLE       3
`define PCR_SYS_BST_HI     2
`define PCR_SYS_BST_LO     1
`define PCR_SYS_CPU_OSCILLATOR_SOURCE       0
`define PCR_IR_ENABLE      7
`define PCR_IR_CARRIER     6
`define PCR_IR_LONG_LOW    5
`define PCR_IR_PIN_SEL     3
`define PCR_IR_TCC_SEL     2
`define PCR_IR_INT1_SEL    1
`define PCR_IR_INT0_SEL    0

// ====================
// reset values
`define PCR_RST_BYTE       8'h00
`define PCR_RST_NIBBLE     4'h0
`define PCR_RST_BANK       2'h0
`define PCR_RST_DIR        4'hF

// ====================
// pll multiplier and booster divider encodings
`define PCR_PLL_X130       8'h82
`define PCR_PLL_X65        8'h41
`define PCR_PLL_X244       8'hF4
`define PCR_BST_DIV1       5'h01
`define PCR_BST_DIV4       5'h04
`define PCR_BST_DIV8       5'h08
`define PCR_BST_DIV16      5'h10

// ====================
// bus responses
`define PCR_RESP_OKAY      2'h0
`define PCR_RESP_SLVERR    2'h2

`endif

// [pcr_sync3.v]
`timescale 1ns/10ps

// ====================
// three-stage pin synchroniser; the filtered value moves only
// once the second and third stages agree
module pcr_sync3 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         reset,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  reg [W-1:0] q_r;
  genvar i;

  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (reset) begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
          s3_r[i] <= 1'b0;
          q_r[i]  <= 1'b0;
        end else begin
          s1_r[i] <= d[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            q_r[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

  assign q = q_r;
endmodule // pcr_sync3

// [pcr_regs.v]
`timescale 1ns/10ps
`include "pcr_defs.vh"

module pcr_regs #(
  parameter ADDR_W = 10
) (
  input  wire              clk,
  input  wire              reset,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output wire [1:0]        s_axi_bresp,
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire [3:0]        p5_in,
  output wire [3:0]        p5_out,
  output wire [3:0]        p5_oe,
  input  wire [7:0]        port6_in,
  input  wire [7:0]        port8_in,
  input  wire              low_pulse_underflow,
  input  wire              high_pulse_underflow,
  input  wire              second_counter_underflow,
  input  wire              first_counter_underflow,
  input  wire              free_timer_overflow,
  input  wire              sleep_instruction,
  input  wire [4:0]        lcd_scan_addr,
  output wire [3:0]        lcd_scan_seg,
  output wire [3:0]        lcd_scan_com,
  output wire [3:0]        counter_run_out,
  output wire [7:0]        pll_mult,
  output wire [1:0]        pll_div_shift,
  output wire [4:0]        booster_divide,
  output wire              main_osc_run,
  output wire              enter_idle,
  output wire              enter_sleep,
  output wire              ctr2_carrier_mode,
  output wire              free_timer_ext_clk
);

  // ====================
  // bus slave state
  reg                  awready_r;
  reg                  wready_r;
  reg                  bvalid_r;
  reg [1:0]            bresp_r;
  reg                  arready_r;
  reg                  rvalid_r;
  reg [1:0]            rresp_r;
  reg [7:0]            rdata_r;
  reg                  aw_held_r;
  reg                  w_held_r;
  reg [`PCR_IDX_W-1:0] widx_r;
  reg [7:0]            wdata_r;
  reg                  wstrb_r;

  // ====================
  // registers and storage
  reg [4:0] lcd_addr_r;
  reg [3:0] lcd_ram [0:31];
  reg [3:0] lcd_com_r;
  reg [3:0] cnt_run_r;
  reg [6:0] sys_ctl_r;
  reg [7:0] ir_ctl_r;
  reg [7:0] irq_flag_r;
  reg [7:0] gpr_lo [0:15];
  reg [7:0] gpr_bank [0:127];
  reg [1:0] bank_sel_r;
  reg [3:0] p5_dir_r;
  reg [3:0] p5_latch_r;

  // ====================
  // output flops and infrared state
  reg [3:0] p5_out_r;
  reg [3:0] p5_oe_r;
  reg [3:0] lcd_scan_seg_r;
  reg [3:0] lcd_scan_com_r;
  reg [7:0] pll_mult_r;
  reg [1:0] pll_div_shift_r;
  reg [4:0] booster_divide_r;
  reg       enter_idle_r;
  reg       enter_sleep_r;
  reg       ctr2_carrier_mode_r;
  reg       free_timer_ext_clk_r;
  reg       ir_phase_r;
  reg       carrier_r;
  reg [3:0] p5_prev_r;
  reg [15:0] port_prev_r;

  wire [3:0]  p5_sync;
  wire [15:0] port_sync;

  pcr_sync3 #(.W(20)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({p5_in, port6_in, port8_in}),
    .q     ({p5_sync, port_sync})
  );

  // ====================
  // write channel
  wire aw_take  = s_axi_awvalid & awready_r;
  wire w_take   = s_axi_wvalid & wready_r;
  wire do_write = aw_held_r & w_held_r & ~bvalid_r;
  wire aw_held_nxt = (aw_held_r | aw_take) & ~do_write;
  wire w_held_nxt  = (w_held_r | w_take) & ~do_write;
  wire bvalid_nxt  = do_write | (bvalid_r & ~s_axi_bready);
  wire wr_en       = do_write & wstrb_r;

  // a write burst is not possible; the response always follows both halves
  always @(posedge clk) begin
    if (reset) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `PCR_RESP_OKAY;
      widx_r    <= {`PCR_IDX_W{1'b0}};
      wdata_r   <= `PCR_RST_BYTE;
      wstrb_r   <= 1'b0;
    end else begin
      awready_r <= ~aw_held_nxt & ~bvalid_nxt;
      wready_r  <= ~w_held_nxt & ~bvalid_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      bvalid_r  <= bvalid_nxt;
      if (aw_take) begin
        widx_r <= s_axi_awaddr[`PCR_IDX_W+1:2];
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata[7:0];
        wstrb_r <= s_axi_wstrb[0];
      end
      if (do_write) begin
        bresp_r <= idx_mapped(widx_r) ? `PCR_RESP_OKAY : `PCR_RESP_SLVERR;
      end
    end
  end

  function idx_mapped;
    input [`PCR_IDX_W-1:0] idx;
    begin
      idx_mapped = (idx >= `PCR_IDX_LCD_ADDR) && (idx <= `PCR_IDX_P5_DATA);
    end
  endfunction

  // ====================
  // read channel
  wire                  ar_take = s_axi_arvalid & arready_r;
  wire [`PCR_IDX_W-1:0] ridx    = s_axi_araddr[`PCR_IDX_W+1:2];
  wire                  rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);
  wire [`PCR_IDX_W-1:0] gpr_off = ridx - `PCR_IDX_GPR_BANKED;
  reg  [7:0]            rd_nxt;

  always @* begin
    rd_nxt = `PCR_RST_BYTE;
    if (ridx >= `PCR_IDX_GPR_BANKED && ridx <= `PCR_IDX_GPR_HI) begin
      rd_nxt = gpr_bank[{bank_sel_r, gpr_off[4:0]}];
    end else if (ridx >= `PCR_IDX_GPR_LO && ridx < `PCR_IDX_GPR_BANKED) begin
      rd_nxt = gpr_lo[ridx[3:0]];
    end else begin
      case (ridx)
        `PCR_IDX_LCD_ADDR: rd_nxt = {3'h0, lcd_addr_r};
        `PCR_IDX_LCD_BUF:  rd_nxt = {4'h0, lcd_ram[lcd_addr_r]};
        `PCR_IDX_CNT_RUN:  rd_nxt = {4'h0, cnt_run_r};
        `PCR_IDX_SYS_CTL:  rd_nxt = {1'b0, sys_ctl_r};
        `PCR_IDX_IR_CTL:   rd_nxt = ir_ctl_r;
        `PCR_IDX_IRQ_FLAG: rd_nxt = irq_flag_r;
        `PCR_IDX_BANK_SEL: rd_nxt = {6'h00, bank_sel_r};
        `PCR_IDX_LCD_COM:  rd_nxt = {4'h0, lcd_com_r};
        `PCR_IDX_P5_DIR:   rd_nxt = {p5_dir_r, 4'h0};
        `PCR_IDX_P5_DATA:  rd_nxt = {p5_sync, 4'h0};
        default:           rd_nxt = `PCR_RST_BYTE;
      endcase
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= `PCR_RESP_OKAY;
      rdata_r   <= `PCR_RST_BYTE;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= rd_nxt;
        rresp_r <= idx_mapped(ridx) ? `PCR_RESP_OKAY : `PCR_RESP_SLVERR;
      end
    end
  end

  // ====================
  // storage writes; memories carry no reset to keep them plain flops
  wire [`PCR_IDX_W-1:0] woff = widx_r - `PCR_IDX_GPR_BANKED;

  always @(posedge clk) begin
    if (wr_en && widx_r >= `PCR_IDX_GPR_BANKED && widx_r <= `PCR_IDX_GPR_HI) begin
      gpr_bank[{bank_sel_r, woff[4:0]}] <= wdata_r;
    end
    if (wr_en && widx_r >= `PCR_IDX_GPR_LO && widx_r < `PCR_IDX_GPR_BANKED) begin
      gpr_lo[widx_r[3:0]] <= wdata_r;
    end
    if (wr_en && widx_r == `PCR_IDX_LCD_BUF) begin
      lcd_ram[lcd_addr_r] <= wdata_r[3:0];
    end
  end

  // ====================
  // control registers and interrupt flags
  wire       int1_evt  = ir_ctl_r[`PCR_IR_INT1_SEL] & p5_prev_r[1] & ~p5_sync[1];
  wire       int0_evt  = ir_ctl_r[`PCR_IR_INT0_SEL] & p5_prev_r[0] & ~p5_sync[0];
  wire       chg_evt   = |(port_prev_r ^ port_sync);
  wire [7:0] flag_set  = {chg_evt, low_pulse_underflow, high_pulse_underflow,
                          second_counter_underflow, first_counter_underflow,
                          int1_evt, int0_evt, free_timer_overflow};
  wire [7:0] flag_clr  = (wr_en && widx_r == `PCR_IDX_IRQ_FLAG) ? wdata_r : 8'h00;

  always @(posedge clk) begin
    if (reset) begin
      lcd_addr_r  <= 5'h00;
      lcd_com_r   <= `PCR_RST_NIBBLE;
      cnt_run_r   <= `PCR_RST_NIBBLE;
      sys_ctl_r   <= 7'h00;
      ir_ctl_r    <= `PCR_RST_BYTE;
      irq_flag_r  <= `PCR_RST_BYTE;
      bank_sel_r  <= `PCR_RST_BANK;
      p5_dir_r    <= `PCR_RST_DIR;
      p5_latch_r  <= `PCR_RST_NIBBLE;
      p5_prev_r   <= `PCR_RST_NIBBLE;
      port_prev_r <= 16'h0000;
    end else begin
      p5_prev_r   <= p5_sync;
      port_prev_r <= port_sync;
      // a new event wins over a clear in the same cycle
      irq_flag_r  <= (irq_flag_r & ~flag_clr) | flag_set;
      if (wr_en) begin
        case (widx_r)
          `PCR_IDX_LCD_ADDR: lcd_addr_r <= wdata_r[4:0];
          `PCR_IDX_LCD_COM:  lcd_com_r  <= wdata_r[3:0];
          // bits 7..4 are not stored, so a stray one cannot stick
          `PCR_IDX_CNT_RUN:  cnt_run_r  <= wdata_r[3:0];
          `PCR_IDX_SYS_CTL:  sys_ctl_r  <= wdata_r[6:0];
          `PCR_IDX_IR_CTL:   ir_ctl_r   <= {wdata_r[7:5], 1'b0, wdata_r[3:0]};
          `PCR_IDX_BANK_SEL: bank_sel_r <= wdata_r[1:0];
          `PCR_IDX_P5_DIR:   p5_dir_r   <= wdata_r[7:4];
          `PCR_IDX_P5_DATA:  p5_latch_r <= wdata_r[7:4];
          default:           lcd_addr_r <= lcd_addr_r;
        endcase
      end
    end
  end

  // ====================
  // infrared / pwm waveform
  wire ir_on    = ir_ctl_r[`PCR_IR_ENABLE];
  wire ir_mod   = ir_ctl_r[`PCR_IR_CARRIER];
  wire ir_long  = ir_ctl_r[`PCR_IR_LONG_LOW];
  wire ir_wave  = ir_phase_r | (ir_mod & carrier_r);

  always @(posedge clk) begin
    if (reset) begin
      ir_phase_r <= 1'b1;
      carrier_r  <= 1'b0;
    end else if (!ir_on) begin
      ir_phase_r <= 1'b1;
      carrier_r  <= 1'b0;
    end else begin
      if (second_counter_underflow) begin
        carrier_r <= ~carrier_r;
      end
      if (ir_long) begin
        if (low_pulse_underflow) begin
          ir_phase_r <= ~ir_phase_r;
        end
      end else if (ir_phase_r && high_pulse_underflow) begin
        ir_phase_r <= 1'b0;
      end else if (!ir_phase_r && low_pulse_underflow) begin
        ir_phase_r <= 1'b1;
      end
    end
  end

  // ====================
  // decoded outputs, all registered
  reg [3:0] p5_out_nxt;

  always @* begin
    p5_out_nxt = p5_latch_r;
    if (ir_ctl_r[`PCR_IR_PIN_SEL] && ir_on) begin
      p5_out_nxt[3] = ir_wave;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      p5_out_r             <= `PCR_RST_NIBBLE;
      p5_oe_r              <= `PCR_RST_NIBBLE;
      lcd_scan_seg_r       <= `PCR_RST_NIBBLE;
      lcd_scan_com_r       <= `PCR_RST_NIBBLE;
      pll_mult_r           <= `PCR_PLL_X130;
      pll_div_shift_r      <= 2'h0;
      booster_divide_r     <= `PCR_BST_DIV1;
      enter_idle_r         <= 1'b0;
      enter_sleep_r        <= 1'b0;
      ctr2_carrier_mode_r  <= 1'b0;
      free_timer_ext_clk_r <= 1'b0;
    end else begin
      p5_out_r       <= p5_out_nxt;
      p5_oe_r        <= ~p5_dir_r;
      lcd_scan_seg_r <= lcd_ram[lcd_scan_addr];
      lcd_scan_com_r <= lcd_com_r;
      enter_idle_r   <= sleep_instruction & sys_ctl_r[`PCR_SYS_IDLE];
      enter_sleep_r  <= sleep_instruction & ~sys_ctl_r[`PCR_SYS_IDLE];
      ctr2_carrier_mode_r  <= ir_on & ir_mod;
      free_timer_ext_clk_r <= ir_ctl_r[`PCR_IR_TCC_SEL] & p5_sync[2];
      case (sys_ctl_r[`PCR_SYS_PLL_HI:`PCR_SYS_PLL_LO])
        3'h0: begin
          pll_mult_r      <= `PCR_PLL_X130;
          pll_div_shift_r <= 2'h0;
        end
        3'h1: begin
          pll_mult_r      <= `PCR_PLL_X65;
          pll_div_shift_r <= 2'h0;
        end
        3'h2: begin
          pll_mult_r      <= `PCR_PLL_X65;
          pll_div_shift_r <= 2'h1;
        end
        3'h3: begin
          pll_mult_r      <= `PCR_PLL_X65;
          pll_div_shift_r <= 2'h2;
        end
        default: begin
          pll_mult_r      <= `PCR_PLL_X244;
          pll_div_shift_r <= 2'h0;
        end
      endcase
      case (sys_ctl_r[`PCR_SYS_BST_HI:`PCR_SYS_BST_LO])
        2'h0:    booster_divide_r <= `PCR_BST_DIV1;
        2'h1:    booster_divide_r <= `PCR_BST_DIV4;
        2'h2:    booster_divide_r <= `PCR_BST_DIV8;
        default: booster_divide_r <= `PCR_BST_DIV16;
      endcase
    end
  end

  assign s_axi_awready     = awready_r;
  assign s_axi_wready      = wready_r;
  assign s_axi_bvalid      = bvalid_r;
  assign s_axi_bresp       = bresp_r;
  assign s_axi_arready     = arready_r;
  assign s_axi_rvalid      = rvalid_r;
  assign s_axi_rresp       = rresp_r;
  assign s_axi_rdata       = {24'h000000, rdata_r};
  assign p5_out            = p5_out_r;
  assign p5_oe             = p5_oe_r;
  assign lcd_scan_seg      = lcd_scan_seg_r;
  assign lcd_scan_com      = lcd_scan_com_r;
  assign counter_run_out   = cnt_run_r;
  assign pll_mult          = pll_mult_r;
  assign pll_div_shift     = pll_div_shift_r;
  assign booster_divide    = booster_divide_r;
  assign main_osc_run      = sys_ctl_r[`PCR_SYS_CPU_OSCILLATOR_SOURCE];
  assign enter_idle        = enter_idle_r;
  assign enter_sleep       = enter_sleep_r;
  assign ctr2_carrier_mode = ctr2_carrier_mode_r;
  assign free_timer_ext_clk = free_timer_ext_clk_r;
endmodule // pcr_regs

// [pcr_checker.sv]
`timescale 1ns/10ps
`include "pcr_defs.vh"

// ====================
// port checks for the register bank
module pcr_checker #(
  parameter ADDR_W = 10
) (
  input wire              clk,
  input wire              reset,
  input wire              s_axi_awvalid,
  input wire              s_axi_awready,
  input wire              s_axi_wvalid,
  input wire              s_axi_wready,
  input wire [1:0]        s_axi_bresp,
  input wire              s_axi_bvalid,
  input wire              s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire              s_axi_arvalid,
  input wire              s_axi_arready,
  input wire [31:0]       s_axi_rdata,
  input wire              s_axi_rvalid,
  input wire              s_axi_rready,
  input wire              sleep_instruction,
  input wire [3:0]        counter_run_out,
  input wire [7:0]        pll_mult,
  input wire [1:0]        pll_div_shift,
  input wire [4:0]        booster_divide,
  input wire              main_osc_run,
  input wire              enter_idle,
  input wire              enter_sleep
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // index of the read in flight, so read data can be judged per register
  reg [6:0] rd_idx_r;
  always @(posedge clk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_idx_r <= s_axi_araddr[8:2];
    end
  end

  chk_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not one cycle after address");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_nibble_only: assert property (s_axi_rvalid && rd_idx_r == `PCR_IDX_LCD_BUF |-> s_axi_rdata[31:4] == 28'h0)
    else $error("lcd buffer upper bits not zero");
  chk_run_on_write: assert property ($changed(counter_run_out) |-> $rose(s_axi_bvalid))
    else $error("counter enables moved without a write");
  chk_osc_on_write: assert property ($changed(main_osc_run) |-> $rose(s_axi_bvalid))
    else $error("oscillator source moved without a write");
  chk_sleep_mode: assert property (sleep_instruction |=> enter_idle ^ enter_sleep)
    else $error("sleep instruction gave no single mode");
  chk_no_stray: assert property (!sleep_instruction |=> !enter_idle && !enter_sleep)
    else $error("mode entry without sleep instruction");
  chk_pll_code: assert property (pll_div_shift != 2'h0 |-> pll_mult == `PCR_PLL_X65)
    else $error("pll divide used with wrong multiplier");
  chk_booster_code: assert property (booster_divide inside {5'h01, 5'h04, 5'h08, 5'h10})
    else $error("booster divider not 1, 4, 8 or 16");
endmodule // pcr_checker

bind pcr_regs pcr_checker #(.ADDR_W(ADDR_W)) u_chk (
  .clk(clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .sleep_instruction(sleep_instruction), .counter_run_out(counter_run_out),
  .pll_mult(pll_mult), .pll_div_shift(pll_div_shift), .booster_divide(booster_divide),
  .main_osc_run(main_osc_run), .enter_idle(enter_idle), .enter_sleep(enter_sleep)
);

// [pcr_regs_tb.sv]
`timescale 1ns/10ps
`include "pcr_defs.vh"

// ====================
// self-checking bench for the register bank
module pcr_regs_tb;
  reg         clk, reset, sleep_instruction;
  reg  [9:0]  s_axi_awaddr, s_axi_araddr;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [31:0] s_axi_wdata;
  reg  [3:0]  s_axi_wstrb, p5_in;
  reg  [7:0]  port6_in, port8_in, d;
  reg  [4:0]  ev, lcd_scan_addr;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp, pll_div_shift;
  wire [31:0] s_axi_rdata;
  wire [3:0]  p5_out, p5_oe, lcd_scan_seg, lcd_scan_com, counter_run_out;
  wire [7:0]  pll_mult;
  wire [4:0]  booster_divide;
  wire        main_osc_run, enter_idle, enter_sleep, ctr2_carrier_mode, free_timer_ext_clk;
  integer     error_cnt, checks_done, i;

  pcr_regs #(.ADDR_W(10)) u_dut (
    .clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .p5_in(p5_in), .p5_out(p5_out), .p5_oe(p5_oe), .port6_in(port6_in), .port8_in(port8_in),
    .low_pulse_underflow(ev[4]), .high_pulse_underflow(ev[3]),
    .second_counter_underflow(ev[2]), .first_counter_underflow(ev[1]),
    .free_timer_overflow(ev[0]), .sleep_instruction(sleep_instruction),
    .lcd_scan_addr(lcd_scan_addr), .lcd_scan_seg(lcd_scan_seg), .lcd_scan_com(lcd_scan_com),
    .counter_run_out(counter_run_out), .pll_mult(pll_mult), .pll_div_shift(pll_div_shift),
    .booster_divide(booster_divide), .main_osc_run(main_osc_run), .enter_idle(enter_idle),
    .enter_sleep(enter_sleep), .ctr2_carrier_mode(ctr2_carrier_mode),
    .free_timer_ext_clk(free_timer_ext_clk)
  );

  always #25 clk = ~clk;

  // ====================
  // reporting
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask

  task check(input [8*10-1:0] what, input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task hang;
    begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH bus wait expected answer seen none");
      close_out;
    end
  endtask

  // ====================
  // bus master: address and data offered together, each dropped when taken
  task wr(input [6:0] idx, input [7:0] v, input [3:0] st, input [1:0] er);
    integer n;
    begin
      s_axi_awaddr <= {1'b0, idx, 2'b00};
      s_axi_wdata <= {24'h0, v};
      s_axi_wstrb <= st;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (n = 0; n < 40; n = n + 1) begin
        @(posedge clk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          check("bresp", s_axi_bresp, er);
          s_axi_bready <= 1'b0;
          n = 99;
        end
      end
      if (n != 100) hang;
      @(posedge clk);
    end
  endtask

  task rd(input [6:0] idx, input [7:0] exp, input [1:0] er);
    integer n;
    begin
      s_axi_araddr <= {1'b0, idx, 2'b00};
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (n = 0; n < 40; n = n + 1) begin
        @(posedge clk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          check("rresp", s_axi_rresp, er);
          check("rdata", s_axi_rdata, {24'h0, exp});
          s_axi_rready <= 1'b0;
          n = 99;
        end
      end
      if (n != 100) hang;
      @(posedge clk);
    end
  endtask

  // ====================
  // scenarios
  task t_reset;
    begin
      check("pll_mult", pll_mult, 130);
      check("booster", booster_divide, 1);
      check("main_osc", main_osc_run, 0);
      check("p5_oe", p5_oe, 0);
      rd(`PCR_IDX_IRQ_FLAG, 8'h00, `PCR_RESP_OKAY);
    end
  endtask

  task t_run;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wr(`PCR_IDX_CNT_RUN, 8'h01 << i, 4'h1, `PCR_RESP_OKAY);
        check("run_out", counter_run_out, 4'h1 << i);
      end
      wr(`PCR_IDX_CNT_RUN, 8'h5F, 4'h1, `PCR_RESP_OKAY);
      rd(`PCR_IDX_CNT_RUN, 8'h0F, `PCR_RESP_OKAY);
      // a write with no byte lane enabled must leave the enables running
      wr(`PCR_IDX_CNT_RUN, 8'h00, 4'h0, `PCR_RESP_OKAY);
      check("run_hold", counter_run_out, 4'hF);
      wr(`PCR_IDX_CNT_RUN, 8'h00, 4'h1, `PCR_RESP_OKAY);
      check("run_stop", counter_run_out, 4'h0);
    end
  endtask

  task t_sys;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        d = {1'b0, i[2:0], 1'b0, i[1:0], i[0]};
        wr(`PCR_IDX_SYS_CTL, d, 4'h1, `PCR_RESP_OKAY);
        check("pll_mult", pll_mult, i[2] ? 244 : (i == 0 ? 130 : 65));
        check("pll_shift", pll_div_shift, (i[2] || i == 0) ? 0 : i - 1);
        check("booster", booster_divide, i[1:0] == 0 ? 1 : 2 << i[1:0]);
        check("main_osc", main_osc_run, i[0]);
        rd(`PCR_IDX_SYS_CTL, d, `PCR_RESP_OKAY);
      end
    end
  endtask

  task t_sleep;
    begin
      for (i = 0; i < 2; i = i + 1) begin
        wr(`PCR_IDX_SYS_CTL, i ? 8'h08 : 8'h00, 4'h1, `PCR_RESP_OKAY);
        sleep_instruction <= 1'b1;
        @(posedge clk);
        sleep_instruction <= 1'b0;
        @(posedge clk);
        check("idle", enter_idle, i);
        check("sleep", enter_sleep, !i);
      end
    end
  endtask

  task t_lcd;
    begin
      wr(`PCR_IDX_LCD_ADDR, 8'h05, 4'h1, `PCR_RESP_OKAY);
      wr(`PCR_IDX_LCD_BUF, 8'hA9, 4'h1, `PCR_RESP_OKAY);
      wr(`PCR_IDX_LCD_ADDR, 8'h1F, 4'h1, `PCR_RESP_OKAY);
      wr(`PCR_IDX_LCD_BUF, 8'h36, 4'h1, `PCR_RESP_OKAY);
      rd(`PCR_IDX_LCD_BUF, 8'h06, `PCR_RESP_OKAY);
      wr(`PCR_IDX_LCD_COM, 8'h0C, 4'h1, `PCR_RESP_OKAY);
      lcd_scan_addr <= 5'h05;
      repeat (2) @(posedge clk);
      check("scan_seg", lcd_scan_seg, 4'h9);
      check("scan_com", lcd_scan_com, 4'hC);
      wr(`PCR_IDX_LCD_ADDR, 8'h05, 4'h1, `PCR_RESP_OKAY);
      rd(`PCR_IDX_LCD_BUF, 8'h09, `PCR_RESP_OKAY);
    end
  endtask

  task t_gpr;
    begin
      wr(7'h10, 8'h5A, 4'h1, `PCR_RESP_OKAY);
      wr(7'h20, 8'h11, 4'h1, `PCR_RESP_OKAY);
      wr(`PCR_IDX_BANK_SEL, 8'h03, 4'h1, `PCR_RESP_OKAY);
      wr(7'h20, 8'h22, 4'h1, `PCR_RESP_OKAY);
      rd(7'h20, 8'h22, `PCR_RESP_OKAY);
      rd(7'h10, 8'h5A, `PCR_RESP_OKAY);
      wr(`PCR_IDX_BANK_SEL, 8'h00, 4'h1, `PCR_RESP_OKAY);
      rd(7'h20, 8'h11, `PCR_RESP_OKAY);
      wr(7'h50, 8'h01, 4'h1, `PCR_RESP_SLVERR);
      rd(7'h50, 8'h00, `PCR_RESP_SLVERR);
    end
  endtask

  task t_flags;
    begin
      ev <= 5'h1F;
      @(posedge clk);
      ev <= 5'h00;
      rd(`PCR_IDX_IRQ_FLAG, 8'h79, `PCR_RESP_OKAY);
      port6_in <= 8'h10;
      repeat (8) @(posedge clk);
      rd(`PCR_IDX_IRQ_FLAG, 8'hF9, `PCR_RESP_OKAY);
      wr(`PCR_IDX_IRQ_FLAG, 8'hFF, 4'h1, `PCR_RESP_OKAY);
      port8_in <= 8'h80;
      repeat (8) @(posedge clk);
      rd(`PCR_IDX_IRQ_FLAG, 8'h80, `PCR_RESP_OKAY);
      wr(`PCR_IDX_IRQ_FLAG, 8'h80, 4'h1, `PCR_RESP_OKAY);
      rd(`PCR_IDX_IRQ_FLAG, 8'h00, `PCR_RESP_OKAY);
    end
  endtask

  task t_pins;
    begin
      wr(`PCR_IDX_IR_CTL, 8'h03, 4'h1, `PCR_RESP_OKAY);
      p5_in <= 4'hC;
      repeat (8) @(posedge clk);
      rd(`PCR_IDX_IRQ_FLAG, 8'h06, `PCR_RESP_OKAY);
      wr(`PCR_IDX_IR_CTL, 8'h04, 4'h1, `PCR_RESP_OKAY);
      repeat (8) @(posedge clk);
      check("tcc_clk", free_timer_ext_clk, 1);
      p5_in <= 4'h8;
      repeat (8) @(posedge clk);
      check("tcc_clk", free_timer_ext_clk, 0);
      wr(`PCR_IDX_P5_DIR, 8'h70, 4'h1, `PCR_RESP_OKAY);
      wr(`PCR_IDX_P5_DATA, 8'h80, 4'h1, `PCR_RESP_OKAY);
      wr(`PCR_IDX_IR_CTL, 8'h08, 4'h1, `PCR_RESP_OKAY);
      check("p5_oe", p5_oe, 4'h8);
      check("p5_out", p5_out[3], 1);
      for (i = 0; i < 4; i = i + 1) begin
        wr(`PCR_IDX_IR_CTL, {i[1:0], 6'h00}, 4'h1, `PCR_RESP_OKAY);
        check("carrier", ctr2_carrier_mode, i == 3);
      end
      wr(`PCR_IDX_IR_CTL, 8'hFF, 4'h1, `PCR_RESP_OKAY);
      rd(`PCR_IDX_IR_CTL, 8'hEF, `PCR_RESP_OKAY);
      ev <= 5'h10;
      @(posedge clk);
      ev <= 5'h00;
      repeat (2) @(posedge clk);
      check("ir_low", p5_out[3], 0);
      ev <= 5'h04;
      @(posedge clk);
      ev <= 5'h00;
      repeat (2) @(posedge clk);
      check("ir_carrier", p5_out[3], 1);
    end
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 56'h0;
    {port6_in, port8_in, ev, lcd_scan_addr, sleep_instruction} = 27'h0;
    p5_in = 4'hF;
    error_cnt = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset;
    t_run;
    t_sys;
    t_sleep;
    t_lcd;
    t_gpr;
    t_flags;
    t_pins;
    close_out;
  end
endmodule // pcr_regs_tb
